// File: common/snfr_pkg.sv
package snfr_pkg;
	localparam logic [7:0] SNFR_OP_GET = 8'h0f;
	localparam logic [7:0] SNFR_OP_SET = 8'h1f;
	localparam logic [7:0] SNFR_OP_WREN = 8'h06;
	localparam logic [7:0] SNFR_OP_WRDI = 8'h04;
	localparam logic [7:0] SNFR_OP_SOFT_RST = 8'hff;
	localparam logic [7:0] SNFR_ADDR_PROT = 8'ha0;
	localparam logic [7:0] SNFR_ADDR_FEAT = 8'hb0;
	localparam logic [7:0] SNFR_ADDR_STAT = 8'hc0;
	localparam logic [7:0] SNFR_ADDR_DRV = 8'hd0;
	localparam logic [7:0] SNFR_ADDR_XSTAT = 8'hf0;
	localparam logic [7:0] SNFR_PROT_WMASK = 8'hbe;
	localparam logic [7:0] SNFR_FEAT_WMASK = 8'hd1;
	localparam logic [7:0] SNFR_DRV_WMASK = 8'h60;
	localparam logic [7:0] SNFR_PROT_RST = 8'h38;
	localparam logic [7:0] SNFR_FEAT_RST = 8'h10;
	localparam logic [7:0] SNFR_DRV_RST = 8'h00;
	localparam int SNFR_PROT_LOCK_BIT = 7;
	localparam int SNFR_FEAT_QE_BIT = 0;
	localparam int SNFR_FEAT_ECC_BIT = 4;
	localparam logic [1:0] SNFR_ECC_NONE = 2'h0;
	localparam logic [1:0] SNFR_ECC_FIXED = 2'h1;
	localparam logic [1:0] SNFR_ECC_FAIL = 2'h2;
	typedef enum logic [1:0] {
		SNFR_ST_OP = 2'b00,
		SNFR_ST_ADDR = 2'b01,
		SNFR_ST_DATA = 2'b11,
		SNFR_ST_IGNORE = 2'b10
	} snfr_state_t;
endpackage : snfr_pkg

// File: common/snfr_shift_if.sv
`timescale 1ns/1ps
interface snfr_shift_if;
	logic byte_done;
	logic [7:0] byte_in;
	logic load;
	logic [7:0] load_byte;
	logic mosi_out_bit;
	modport ctl(input byte_done, input byte_in, output load, output load_byte, input mosi_out_bit);
	modport shf(output byte_done, output byte_in, input load, input load_byte, output mosi_out_bit);
endinterface : snfr_shift_if

// File: core/snfr_regs.sv
`timescale 1ns/1ps
module snfr_regs (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic por_in,
	input wire logic cs_n_in,
	input wire logic sclk_rise_in,
	input wire logic sclk_fall_in,
	input wire logic si_in,
	input wire logic wp_n_in,
	input wire logic busy_in,
	input wire logic cache_busy_in,
	input wire logic sel_block_locked_in,
	input wire logic prog_start_in,
	input wire logic prog_fail_in,
	input wire logic prog_protected_in,
	input wire logic erase_start_in,
	input wire logic erase_fail_in,
	input wire logic erase_locked_in,
	input wire logic read_start_in,
	input wire logic read_done_in,
	input wire logic [1:0] ecc_result_in,
	input wire logic [1:0] ecc_count_in,
	input wire logic op_clear_latch_in,
	output logic so_out,
	output logic so_oe_out,
	output logic quad_io_enable_out,
	output logic ecc_enable_out,
	output logic onetime_area_lock_out,
	output logic onetime_access_out,
	output logic [2:0] protect_level_out,
	output logic reverse_range_out,
	output logic complement_select_out,
	output logic [1:0] output_drive_level_out,
	output logic write_latch_out,
	output logic soft_reset_out
);
	import snfr_pkg::*;

	snfr_shift_if sh ();
	snfr_state_t state_r;
	logic [7:0] op_r;
	logic [7:0] addr_r;
	logic [7:0] prot_r;
	logic [7:0] feat_r;
	logic [7:0] drv_r;
	logic [1:0] ecc_st_r;
	logic [1:0] ecc_cnt_r;
	logic prog_fail_r;
	logic erase_fail_r;
	logic write_latch_r;
	logic oe_r;
	logic soft_rst_r;
	logic cmd_done;
	logic set_hit;
	logic [7:0] rd_data;
	logic [7:0] stat_byte;
	logic [7:0] xstat_byte;

	snfr_shifter u_shift (
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.cs_n_in(cs_n_in),
		.sclk_rise_in(sclk_rise_in),
		.sclk_fall_in(sclk_fall_in),
		.si_in(si_in),
		.sh(sh)
	);

	assign stat_byte = {2'h0, ecc_st_r, prog_fail_r, erase_fail_r, write_latch_r, busy_in};
	assign xstat_byte = {2'h0, ecc_cnt_r, sel_block_locked_in, 2'h0, cache_busy_in};

	always_comb begin
		unique case (sh.byte_in)
			SNFR_ADDR_PROT: rd_data = prot_r;
			SNFR_ADDR_FEAT: rd_data = feat_r;
			SNFR_ADDR_STAT: rd_data = stat_byte;
			SNFR_ADDR_DRV: rd_data = drv_r;
			SNFR_ADDR_XSTAT: rd_data = xstat_byte;
			default: rd_data = 8'h00;
		endcase
	end

	// Command framing: opcode byte, address byte, then data bytes until select rises for get, or one data byte for set.
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r <= SNFR_ST_OP;
			op_r <= 8'h00;
			addr_r <= 8'h00;
		end else if (cs_n_in) begin
			state_r <= SNFR_ST_OP;
		end else if (sh.byte_done) begin
			unique case (state_r)
				SNFR_ST_OP: begin
					op_r <= sh.byte_in;
					if (sh.byte_in == SNFR_OP_GET || sh.byte_in == SNFR_OP_SET) begin
						state_r <= SNFR_ST_ADDR;
					end else begin
						state_r <= SNFR_ST_IGNORE;
					end
				end
				SNFR_ST_ADDR: begin
					addr_r <= sh.byte_in;
					state_r <= SNFR_ST_DATA;
				end
				SNFR_ST_DATA: state_r <= (op_r == SNFR_OP_SET) ? SNFR_ST_IGNORE : SNFR_ST_DATA;
				SNFR_ST_IGNORE: state_r <= SNFR_ST_IGNORE;
			endcase
		end
	end

	// Reload the same register after every data byte so the host can poll without reissuing.
	assign sh.load = sh.byte_done && !cs_n_in && op_r == SNFR_OP_GET
		&& (state_r == SNFR_ST_DATA || (state_r == SNFR_ST_ADDR));
	assign sh.load_byte = (state_r == SNFR_ST_ADDR) ? rd_data : rd_data_hold(addr_r);

	function automatic logic [7:0] rd_data_hold(input logic [7:0] a);
		unique case (a)
			SNFR_ADDR_PROT: rd_data_hold = prot_r;
			SNFR_ADDR_FEAT: rd_data_hold = feat_r;
			SNFR_ADDR_STAT: rd_data_hold = stat_byte;
			SNFR_ADDR_DRV: rd_data_hold = drv_r;
			SNFR_ADDR_XSTAT: rd_data_hold = xstat_byte;
			default: rd_data_hold = 8'h00;
		endcase
	endfunction : rd_data_hold

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			oe_r <= 1'b0;
		end else if (cs_n_in) begin
			oe_r <= 1'b0;
		end else if (sh.load) begin
			oe_r <= 1'b1;
		end
	end

	assign set_hit = sh.byte_done && !cs_n_in && state_r == SNFR_ST_DATA && op_r == SNFR_OP_SET;

	// Writable registers; soft reset never touches them, only the asynchronous and power-on resets do.
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prot_r <= SNFR_PROT_RST;
			feat_r <= SNFR_FEAT_RST;
			drv_r <= SNFR_DRV_RST;
		end else if (por_in) begin
			prot_r <= SNFR_PROT_RST;
			feat_r <= SNFR_FEAT_RST;
			drv_r <= SNFR_DRV_RST;
		end else if (set_hit) begin
			if (addr_r == SNFR_ADDR_PROT && !(prot_r[SNFR_PROT_LOCK_BIT] && !wp_n_in)) begin
				prot_r <= sh.byte_in & SNFR_PROT_WMASK;
			end
			if (addr_r == SNFR_ADDR_FEAT) begin
				// Once the one-time area is locked it stays locked until power is lost.
				feat_r <= (sh.byte_in & SNFR_FEAT_WMASK) | (feat_r & 8'h80);
			end
			if (addr_r == SNFR_ADDR_DRV) begin
				drv_r <= sh.byte_in & SNFR_DRV_WMASK;
			end
		end
	end

	// Soft reset command is decoded from a lone opcode byte.
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= sh.byte_done && !cs_n_in && state_r == SNFR_ST_OP
				&& sh.byte_in == SNFR_OP_SOFT_RST;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			write_latch_r <= 1'b0;
		end else if (por_in || soft_rst_r) begin
			write_latch_r <= 1'b0;
		end else if (sh.byte_done && !cs_n_in && state_r == SNFR_ST_OP) begin
			if (sh.byte_in == SNFR_OP_WREN) begin
				write_latch_r <= 1'b1;
			end else if (sh.byte_in == SNFR_OP_WRDI) begin
				write_latch_r <= 1'b0;
			end
		end else if (op_clear_latch_in) begin
			write_latch_r <= 1'b0;
		end
	end

	// Set wins over clear so a failure reported in the same cycle is never lost.
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prog_fail_r <= 1'b0;
		end else if (prog_fail_in || prog_protected_in) begin
			prog_fail_r <= 1'b1;
		end else if (prog_start_in || soft_rst_r || por_in) begin
			prog_fail_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			erase_fail_r <= 1'b0;
		end else if (erase_fail_in || erase_locked_in) begin
			erase_fail_r <= 1'b1;
		end else if (erase_start_in || soft_rst_r || por_in) begin
			erase_fail_r <= 1'b0;
		end
	end

	// Completion updates win over a simultaneous start so a result is not dropped.
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ecc_st_r <= SNFR_ECC_NONE;
			ecc_cnt_r <= 2'h0;
		end else if (read_done_in) begin
			// The boot page read after power-on also completes here, giving page 0 status.
			ecc_st_r <= ecc_result_in;
			ecc_cnt_r <= (ecc_result_in == SNFR_ECC_FIXED) ? ecc_count_in : 2'h0;
		end else if (read_start_in || soft_rst_r || por_in) begin
			ecc_st_r <= SNFR_ECC_NONE;
			ecc_cnt_r <= 2'h0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			so_out <= 1'b0;
			so_oe_out <= 1'b0;
			quad_io_enable_out <= 1'b0;
			ecc_enable_out <= 1'b1;
			onetime_area_lock_out <= 1'b0;
			onetime_access_out <= 1'b0;
			protect_level_out <= 3'h7;
			reverse_range_out <= 1'b0;
			complement_select_out <= 1'b0;
			output_drive_level_out <= 2'h0;
			write_latch_out <= 1'b0;
			soft_reset_out <= 1'b0;
		end else begin
			so_out <= sh.mosi_out_bit;
			so_oe_out <= oe_r && !cs_n_in;
			quad_io_enable_out <= feat_r[SNFR_FEAT_QE_BIT];
			ecc_enable_out <= feat_r[SNFR_FEAT_ECC_BIT];
			onetime_area_lock_out <= feat_r[7];
			onetime_access_out <= feat_r[6];
			protect_level_out <= prot_r[5:3];
			reverse_range_out <= prot_r[2];
			complement_select_out <= prot_r[1];
			output_drive_level_out <= drv_r[6:5];
			write_latch_out <= write_latch_r;
			soft_reset_out <= soft_rst_r;
		end
	end
endmodule : snfr_regs

// File: core/snfr_shifter.sv
`timescale 1ns/1ps
module snfr_shifter (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic cs_n_in,
	input wire logic sclk_rise_in,
	input wire logic sclk_fall_in,
	input wire logic si_in,
	snfr_shift_if.shf sh
);
	logic [2:0] cnt_r;
	logic [7:0] sin_r;
	logic [7:0] sout_r;
	logic done_r;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_r <= 3'h0;
			sin_r <= 8'h00;
			done_r <= 1'b0;
		end else if (cs_n_in) begin
			cnt_r <= 3'h0;
			done_r <= 1'b0;
		end else begin
			done_r <= sclk_rise_in && (cnt_r == 3'h7);
			if (sclk_rise_in) begin
				sin_r <= {sin_r[6:0], si_in};
				cnt_r <= cnt_r + 3'h1;
			end
		end
	end

	// Output changes on the falling edge so the host samples a settled bit before the next fall.
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sout_r <= 8'h00;
		end else if (sh.load) begin
			sout_r <= sh.load_byte;
		end else if (sclk_fall_in && !cs_n_in) begin
			sout_r <= {sout_r[6:0], 1'b0};
		end
	end

	assign sh.byte_done = done_r;
	assign sh.byte_in = sin_r;
	assign sh.mosi_out_bit = sout_r[7];
endmodule : snfr_shifter

// File: verif/snfr_host_model.sv
`timescale 1ns/1ps
module snfr_host_model (
	input wire logic clk_sys_in,
	input wire logic so_in,
	output logic cs_n_out,
	output logic sclk_rise_out,
	output logic sclk_fall_out,
	output logic si_out
);
	initial begin
		cs_n_out = 1'b1;
		sclk_rise_out = 1'b0;
		sclk_fall_out = 1'b0;
		si_out = 1'b0;
	end
	// Bytes go opcode, address, data, MSB first; output bits are taken before each fall.
	task xfer(input logic [23:0] w, input int n, output logic [8:0] rd);
		logic [15:0] sh;
		sh = 16'h0000;
		cs_n_out <= 1'b0;
		@(posedge clk_sys_in);
		for (int i = 23; i > 23 - 8 * n; i--) begin
			si_out <= w[i];
			sclk_rise_out <= 1'b1;
			@(posedge clk_sys_in);
			sclk_rise_out <= 1'b0;
			repeat (3) @(posedge clk_sys_in);
			sclk_fall_out <= 1'b1;
			@(negedge clk_sys_in);
			sh = {sh[14:0], so_in};
			@(posedge clk_sys_in);
			sclk_fall_out <= 1'b0;
			repeat (2) @(posedge clk_sys_in);
		end
		cs_n_out <= 1'b1;
		// A released line must not keep showing its last bit.
		si_out <= ~si_out;
		repeat (6) @(posedge clk_sys_in);
		rd = sh[8:0];
	endtask : xfer
endmodule : snfr_host_model

// File: verif/snfr_regs_props.sv
`timescale 1ns/1ps
module snfr_regs_props (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic por_in,
	input wire logic cs_n_in,
	input wire logic op_clear_latch_in,
	input wire logic so_oe_out,
	input wire logic soft_reset_out,
	input wire logic write_latch_out,
	input wire logic quad_io_enable_out,
	input wire logic ecc_enable_out,
	input wire logic onetime_area_lock_out,
	input wire logic [2:0] protect_level_out,
	input wire logic [1:0] output_drive_level_out
);
	wire logic [7:0] cfg = {quad_io_enable_out, ecc_enable_out, onetime_area_lock_out,
		protect_level_out, output_drive_level_out};
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);
	// Reset is asynchronous, so its values must already show while it is held.
	a_reset_vals: assert property (disable iff (1'b0) !arst_n_in |-> ecc_enable_out
		&& protect_level_out == 3'h7 && !so_oe_out && !write_latch_out)
		else $error("reset values wrong");
	a_por_defaults: assert property (por_in |-> ##[1:2] (protect_level_out == 3'h7
		&& ecc_enable_out && !quad_io_enable_out && !onetime_area_lock_out))
		else $error("power-on defaults wrong");
	a_cfg_quiet: assert property ((cs_n_in && !por_in) [*5] |-> $stable(cfg))
		else $error("config moved without command");
	a_soft_keep: assert property (soft_reset_out |-> $stable(cfg) ##1 $stable(cfg))
		else $error("soft reset moved config");
	a_soft_pulse: assert property (soft_reset_out |-> !$past(cs_n_in) ##1 !soft_reset_out)
		else $error("soft reset pulse wrong");
	a_latch_clear: assert property (op_clear_latch_in |-> ##[1:2] !write_latch_out)
		else $error("write latch kept");
	a_lock_sticky: assert property ($fell(onetime_area_lock_out) |-> $past(por_in)
		|| $past(por_in, 2)) else $error("one-time lock dropped");
	a_oe_release: assert property (cs_n_in |=> !so_oe_out)
		else $error("output driven while deselected");
endmodule : snfr_regs_props

// File: verif/tb_serial_nand_feature_regs.sv
`timescale 1ns/1ps
module tb_serial_nand_feature_regs;
	import snfr_pkg::*;
	logic clk_sys_in = 1'b0;
	logic arst_n_in = 1'b1;
	logic por_in = 1'b0;
	logic wp_n_in = 1'b1;
	logic [2:0] lv = 3'h0;
	logic [8:0] ev = 9'h000;
	logic [3:0] ecc = 4'h0;
	logic cs_n, rise, fall, si, so, oe, qe, ee, ol, oa, rev, cmp, wl, sr;
	logic [2:0] lvl;
	logic [1:0] drv;
	logic [8:0] rd;
	int checks = 0;
	int n_fail = 0;
	// Set address (00 for none), set data, get address, expected byte.
	logic [31:0] rows [11] = '{32'h0000a038, 32'h0000b010, 32'h0000d000, 32'h0000c000,
		32'h0000f000, 32'ha02ca02c, 32'hb051b051, 32'hd040d040, 32'hc0ffc000,
		32'hf0fff000, 32'h55ffa02c};
	// Event pulse mask, then the status byte it should leave.
	logic [16:0] fl [9] = '{17'h00208, 17'h00100, 17'h00408, 17'h00308, 17'h00100,
		17'h01004, 17'h00800, 17'h02004, 17'h01804};
	always #12.5 clk_sys_in = ~clk_sys_in;
	snfr_regs u_snfr_regs (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .por_in(por_in),
		.cs_n_in(cs_n), .sclk_rise_in(rise), .sclk_fall_in(fall), .si_in(si),
		.wp_n_in(wp_n_in), .busy_in(lv[0]), .cache_busy_in(lv[1]),
		.sel_block_locked_in(lv[2]), .prog_start_in(ev[0]), .prog_fail_in(ev[1]),
		.prog_protected_in(ev[2]), .erase_start_in(ev[3]), .erase_fail_in(ev[4]),
		.erase_locked_in(ev[5]), .read_start_in(ev[6]), .read_done_in(ev[7]),
		.ecc_result_in(ecc[3:2]), .ecc_count_in(ecc[1:0]), .op_clear_latch_in(ev[8]),
		.so_out(so), .so_oe_out(oe), .quad_io_enable_out(qe), .ecc_enable_out(ee),
		.onetime_area_lock_out(ol), .onetime_access_out(oa), .protect_level_out(lvl),
		.reverse_range_out(rev), .complement_select_out(cmp),
		.output_drive_level_out(drv), .write_latch_out(wl), .soft_reset_out(sr));
	snfr_host_model u_snfr_host_model (.clk_sys_in(clk_sys_in), .so_in(so),
		.cs_n_out(cs_n), .sclk_rise_out(rise), .sclk_fall_out(fall), .si_out(si));
	task summarize;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	task chk(input string n, input logic [7:0] e, input logic [7:0] v);
		checks++;
		if (v !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", n, e, v);
		end
	endtask : chk
	task g(input logic [7:0] a, input logic [7:0] e);
		u_snfr_host_model.xfer({SNFR_OP_GET, a, 8'h00}, 3, rd);
		chk("get", e, rd[8:1]);
		chk("repeat", {7'h00, e[7]}, {7'h00, rd[0]});
	endtask : g
	task s(input logic [7:0] a, input logic [7:0] d);
		u_snfr_host_model.xfer({SNFR_OP_SET, a, d}, 3, rd);
	endtask : s
	task op(input logic [7:0] o);
		u_snfr_host_model.xfer({o, 16'h0000}, 1, rd);
	endtask : op
	task p(input logic [8:0] m);
		ev <= m;
		@(posedge clk_sys_in);
		ev <= 9'h000;
		repeat (3) @(posedge clk_sys_in);
	endtask : p
	initial begin
		repeat (40000) @(posedge clk_sys_in);
		n_fail++;
		summarize();
	end
	initial begin
		// A real falling edge at time zero lets the asynchronous reset act before the first clock.
		arst_n_in <= 1'b0;
		repeat (6) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		foreach (rows[i]) begin
			if (rows[i][31:24] != 8'h00)
				s(rows[i][31:24], rows[i][23:16]);
			g(rows[i][15:8], rows[i][7:0]);
		end
		chk("outs", 8'hf6, {qe, ee, oa, lvl, rev, cmp});
		chk("pins", 8'h02, {4'h0, ol, wl, drv});
		u_snfr_host_model.xfer({8'h5a, SNFR_ADDR_DRV, 8'h00}, 3, rd);
		g(SNFR_ADDR_DRV, 8'h40);
		$display("test table done");
		op(SNFR_OP_WREN);
		g(SNFR_ADDR_STAT, 8'h02);
		chk("pins", 8'h06, {4'h0, ol, wl, drv});
		op(SNFR_OP_WRDI);
		g(SNFR_ADDR_STAT, 8'h00);
		op(SNFR_OP_WREN);
		p(9'h100);
		g(SNFR_ADDR_STAT, 8'h00);
		op(SNFR_OP_WREN);
		op(SNFR_OP_SOFT_RST);
		g(SNFR_ADDR_STAT, 8'h00);
		g(SNFR_ADDR_PROT, 8'h2c);
		g(SNFR_ADDR_FEAT, 8'h51);
		$display("test latch done");
		s(SNFR_ADDR_PROT, 8'hac);
		wp_n_in <= 1'b0;
		s(SNFR_ADDR_PROT, 8'h38);
		g(SNFR_ADDR_PROT, 8'hac);
		wp_n_in <= 1'b1;
		s(SNFR_ADDR_PROT, 8'h38);
		g(SNFR_ADDR_PROT, 8'h38);
		foreach (fl[i]) begin
			p(fl[i][16:8]);
			g(SNFR_ADDR_STAT, fl[i][7:0]);
		end
		op(SNFR_OP_SOFT_RST);
		g(SNFR_ADDR_STAT, 8'h00);
		$display("test flags done");
		// Correction stays enabled, so the status fields carry meaning here.
		ecc <= 4'h7;
		p(9'h080);
		g(SNFR_ADDR_STAT, 8'h10);
		g(SNFR_ADDR_XSTAT, 8'h30);
		p(9'h040);
		g(SNFR_ADDR_STAT, 8'h00);
		ecc <= 4'h8;
		p(9'h0c0);
		g(SNFR_ADDR_STAT, 8'h20);
		op(SNFR_OP_SOFT_RST);
		g(SNFR_ADDR_STAT, 8'h00);
		lv <= 3'h7;
		@(posedge clk_sys_in);
		g(SNFR_ADDR_STAT, 8'h01);
		g(SNFR_ADDR_XSTAT, 8'h09);
		lv <= 3'h0;
		s(SNFR_ADDR_FEAT, 8'hd0);
		s(SNFR_ADDR_FEAT, 8'h10);
		g(SNFR_ADDR_FEAT, 8'h90);
		chk("pins", 8'h0a, {4'h0, ol, wl, drv});
		por_in <= 1'b1;
		@(posedge clk_sys_in);
		por_in <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		g(SNFR_ADDR_PROT, 8'h38);
		g(SNFR_ADDR_FEAT, 8'h10);
		g(SNFR_ADDR_DRV, 8'h00);
		chk("outs", 8'h5c, {qe, ee, oa, lvl, rev, cmp});
		chk("pins", 8'h00, {4'h0, ol, wl, drv});
		$display("test status done");
		summarize();
	end
endmodule : tb_serial_nand_feature_regs
bind snfr_regs snfr_regs_props u_snfr_regs_props (.clk_sys_in, .arst_n_in, .por_in, .cs_n_in,
	.op_clear_latch_in, .so_oe_out, .soft_reset_out, .write_latch_out, .quad_io_enable_out,
	.ecc_enable_out, .onetime_area_lock_out, .protect_level_out, .output_drive_level_out);
